// [src/tft_fence_table.sv]
// Tiled fence table: AXI4-Lite register file and linear-to-tiled lookup
//
// Local design decisions: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
module tft_fence_table
  import tft_pkg::*;
#(
  parameter int DEPTH = TFT_DEPTH,
  parameter int IW = TFT_IW
)
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic chip_rst,
  input wire logic ce,
  input wire logic [TFT_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [TFT_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire tft_req_s acc_req,
  input wire logic acc_valid,
  output logic acc_ready,
  output tft_rsp_s acc_rsp,
  output logic acc_rsp_valid,
  input wire logic acc_rsp_ready
);
  typedef enum logic [2:0] {B_IDLE, B_BRESP, B_RWAIT, B_RRESP} tft_bus_e;
  typedef enum logic [1:0] {L_IDLE, L_SCAN, L_XLATE, L_RESP} tft_look_e;

  tft_bus_e bst_q;
  tft_look_e lst_q;
  logic aw_have_q, w_have_q;
  logic [TFT_AW-1:0] awaddr_q, raddr_q;
  logic [31:0] wdata_q, rdata_q, ctrl_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  logic [IW:0] scan_q;
  logic cmp_v_q;
  logic [IW-1:0] cmp_idx_q;
  logic [31:0] acc_addr_q;
  tft_entry_s ent_q;
  tft_rsp_s rsp_q;

  // ==========================================================================
  // Bus address decode
  wire w_in_table = awaddr_q >= TFT_TABLE_BASE && awaddr_q < TFT_TABLE_END;
  wire w_is_ctrl = awaddr_q == TFT_CTRL_OFF;
  wire r_in_table = raddr_q >= TFT_TABLE_BASE && raddr_q < TFT_TABLE_END;
  wire r_is_ctrl = raddr_q == TFT_CTRL_OFF;
  wire r_is_stat = raddr_q == TFT_STAT_OFF;
  wire [IW-1:0] w_idx = awaddr_q[IW+2:3];
  wire w_hi = awaddr_q[2];
  wire do_write = bst_q == B_IDLE && aw_have_q && w_have_q;
  wire tbl_we = do_write && w_in_table;
  wire [7:0] tbl_be = w_hi ? {wstrb_q, 4'h0} : {4'h0, wstrb_q};
  // Bound fields live in byte lanes 3:1 of both words
  wire bound_write = tbl_we && (|wstrb_q[3:1]);
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire [IW-1:0] ar_idx = s_axi_araddr[IW+2:3];

  // Handshakes held off while frozen, else a transfer is lost; ce must not drop under a pending answer
  assign s_axi_awready = ce && bst_q == B_IDLE && !aw_have_q;
  assign s_axi_wready = ce && bst_q == B_IDLE && !w_have_q;
  assign s_axi_arready = ce && bst_q == B_IDLE && !(aw_have_q && w_have_q);
  assign s_axi_bvalid = ce && bst_q == B_BRESP;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = ce && bst_q == B_RRESP;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  logic [63:0] a_rdata, b_rdata;

  tft_table_mem #(
    .DEPTH(DEPTH),
    .IW(IW)
  ) u_mem (
    .mclk(mclk),
    .ce(ce),
    .chip_rst(chip_rst),
    .we(tbl_we),
    .waddr(w_idx),
    .wbe(tbl_be),
    .wdata({wdata_q, wdata_q}),
    .a_addr(ar_idx),
    .a_rdata(a_rdata),
    .b_addr(scan_q[IW-1:0]),
    .b_rdata(b_rdata)
  );

  // ==========================================================================
  // Bus read data selection
  wire [31:0] stat_word = {24'h0, rsp_q.hit, rsp_q.idx, 1'h0, lst_q};
  wire [31:0] tbl_word = raddr_q[2] ? a_rdata[63:32] : a_rdata[31:0];
  wire [31:0] rd_word = r_in_table ? tbl_word : r_is_ctrl ? ctrl_q : r_is_stat ? stat_word : 32'h0000_0000;
  wire [1:0] rd_resp = (r_in_table || r_is_ctrl || r_is_stat) ? TFT_RESP_OKAY : TFT_RESP_SLVERR;

  // ==========================================================================
  // Bus slave
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      bst_q <= B_IDLE;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= '0;
      raddr_q <= '0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bresp_q <= TFT_RESP_OKAY;
      rresp_q <= TFT_RESP_OKAY;
      rdata_q <= 32'h0000_0000;
      ctrl_q <= TFT_CTRL_RESET;
    end
    else if (ce)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      case (bst_q)
        B_IDLE:
        begin
          if (do_write)
          begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            bresp_q <= (w_in_table || w_is_ctrl) ? TFT_RESP_OKAY : TFT_RESP_SLVERR;
            if (w_is_ctrl)
            begin
              for (int b = 0; b < 4; b++)
              begin
                if (wstrb_q[b])
                  ctrl_q[8*b +: 8] <= wdata_q[8*b +: 8];
              end
            end
            bst_q <= B_BRESP;
          end
          else if (ar_take)
          begin
            raddr_q <= s_axi_araddr;
            bst_q <= B_RWAIT;
          end
        end
        B_BRESP:
        begin
          if (s_axi_bready)
            bst_q <= B_IDLE;
        end
        B_RWAIT:
        begin
          rdata_q <= rd_word;
          rresp_q <= rd_resp;
          bst_q <= B_RRESP;
        end
        B_RRESP:
        begin
          if (s_axi_rready)
            bst_q <= B_IDLE;
        end
        default:
          bst_q <= B_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Range compare on aperture offsets, page granular, both bounds inclusive
  wire tft_entry_s cmp_ent = b_rdata;
  wire [19:0] acc_page = acc_addr_q[31:TFT_PAGE_SHIFT];
  wire cmp_hit = cmp_v_q && cmp_ent.valid
    && acc_page >= cmp_ent.lower && acc_page <= cmp_ent.upper;
  wire scan_last = cmp_v_q && cmp_idx_q == IW'(DEPTH - 1);

  // ==========================================================================
  // Translation
  wire [31:0] base = {ent_q.lower, 12'h000};
  wire [31:0] off = acc_addr_q - base;
  wire [17:0] pitch_b = 18'(({8'h00, ent_q.pitch} + 18'h00001) << TFT_PITCH_UNIT_SHIFT);
  wire [31:0] row = off / {14'h0000, pitch_b};
  wire [31:0] col = off % {14'h0000, pitch_b};
  wire is_y = ent_q.walk == TFT_WALK_Y;
  wire [31:0] tpr = {14'h0000, is_y ? (pitch_b >> TFT_Y_WIDTH_SHIFT) : (pitch_b >> TFT_X_WIDTH_SHIFT)};
  wire [31:0] trow = is_y ? (row >> TFT_Y_ROWS_SHIFT) : (row >> TFT_X_ROWS_SHIFT);
  wire [31:0] tcol = is_y ? (col >> TFT_Y_WIDTH_SHIFT) : (col >> TFT_X_WIDTH_SHIFT);
  wire [31:0] tile_no = 32'(trow * tpr) + tcol;
  // Y tiles are columns of 16-byte units, 32 rows deep
  wire [11:0] in_y = {col[6:TFT_Y_COL_SHIFT], row[4:0], col[3:0]};
  wire [11:0] in_x = {row[2:0], col[8:0]};
  wire [31:0] tiled = base + {tile_no[19:0], 12'h000} + {20'h00000, is_y ? in_y : in_x};

  assign acc_ready = ce && lst_q == L_IDLE;
  assign acc_rsp_valid = ce && lst_q == L_RESP;
  assign acc_rsp = rsp_q;

  // ==========================================================================
  // Lookup sequencer: one entry read per cycle, lowest matching index wins
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      lst_q <= L_IDLE;
      scan_q <= '0;
      cmp_v_q <= 1'b0;
      cmp_idx_q <= '0;
      acc_addr_q <= 32'h0000_0000;
      ent_q <= TFT_ENTRY_RESET;
      rsp_q <= '0;
    end
    else if (ce)
    begin
      case (lst_q)
        L_IDLE:
        begin
          if (acc_valid)
          begin
            acc_addr_q <= acc_req.addr;
            scan_q <= '0;
            cmp_v_q <= 1'b0;
            if (ctrl_q[0])
              lst_q <= L_SCAN;
            else
            begin
              rsp_q <= '{hit: 1'b0, idx: '0, addr: acc_req.addr};
              lst_q <= L_RESP;
            end
          end
        end
        L_SCAN:
        begin
          if (bound_write)
          begin
            // Entries may have moved under the scan; start over
            scan_q <= '0;
            cmp_v_q <= 1'b0;
          end
          else if (cmp_hit)
          begin
            ent_q <= cmp_ent;
            rsp_q.idx <= cmp_idx_q;
            lst_q <= L_XLATE;
          end
          else if (scan_last)
          begin
            rsp_q <= '{hit: 1'b0, idx: '0, addr: acc_addr_q};
            lst_q <= L_RESP;
          end
          else
          begin
            cmp_v_q <= scan_q < (IW+1)'(DEPTH);
            cmp_idx_q <= scan_q[IW-1:0];
            scan_q <= scan_q + (IW+1)'(1);
          end
        end
        L_XLATE:
        begin
          if (bound_write)
          begin
            scan_q <= '0;
            cmp_v_q <= 1'b0;
            lst_q <= L_SCAN;
          end
          else
          begin
            rsp_q.hit <= 1'b1;
            rsp_q.addr <= tiled;
            lst_q <= L_RESP;
          end
        end
        L_RESP:
        begin
          if (acc_rsp_ready)
            lst_q <= L_IDLE;
        end
        default:
          lst_q <= L_IDLE;
      endcase
    end
  end
endmodule

// [src/tft_pkg.sv]
// Shared constants and carriers of the tiled fence table
package tft_pkg;
  // ==========================================================================
  // Bus and register map
  localparam int TFT_AW = 16;
  localparam int TFT_DEPTH = 16;
  localparam int TFT_IW = 4;
  localparam logic [TFT_AW-1:0] TFT_TABLE_BASE = 16'h3000;
  localparam logic [TFT_AW-1:0] TFT_TABLE_END = 16'h3080;
  localparam logic [TFT_AW-1:0] TFT_CTRL_OFF = 16'h3080;
  localparam logic [TFT_AW-1:0] TFT_STAT_OFF = 16'h3084;
  localparam logic [31:0] TFT_CTRL_RESET = 32'h0000_0001;
  localparam logic [1:0] TFT_RESP_OKAY = 2'h0;
  localparam logic [1:0] TFT_RESP_SLVERR = 2'h2;

  // ==========================================================================
  // Entry layout
  localparam int TFT_LOWER_LSB = 12;
  localparam int TFT_UPPER_LSB = 44;
  localparam int TFT_PITCH_LSB = 2;
  localparam int TFT_WALK_BIT = 1;
  localparam int TFT_VALID_BIT = 0;
  localparam logic [63:0] TFT_ENTRY_RESET = 64'h0000_0000_0000_0000;
  // Bits 43:32 are reserved and never stored
  localparam logic [63:0] TFT_WMASK = 64'hFFFF_F000_FFFF_FFFF;
  localparam logic TFT_WALK_X = 1'h0;
  localparam logic TFT_WALK_Y = 1'h1;

  // ==========================================================================
  // Tile geometry (log2 of sizes)
  localparam int TFT_PAGE_SHIFT = 12;
  localparam int TFT_PITCH_UNIT_SHIFT = 7;
  localparam int TFT_X_WIDTH_SHIFT = 9;
  localparam int TFT_X_ROWS_SHIFT = 3;
  localparam int TFT_Y_WIDTH_SHIFT = 7;
  localparam int TFT_Y_ROWS_SHIFT = 5;
  localparam int TFT_Y_COL_SHIFT = 4;

  typedef struct packed {
    logic [19:0] upper;
    logic [11:0] rsvd;
    logic [19:0] lower;
    logic [9:0] pitch;
    logic walk;
    logic valid;
  } tft_entry_s;

  typedef struct packed {
    logic [31:0] addr;
  } tft_req_s;

  typedef struct packed {
    logic hit;
    logic [TFT_IW-1:0] idx;
    logic [31:0] addr;
  } tft_rsp_s;
endpackage

// [src/tft_table_mem.sv]
// Fence entry storage with one write port and two registered read ports
`timescale 1ns/1ps
module tft_table_mem
  import tft_pkg::*;
#(
  parameter int DEPTH = TFT_DEPTH,
  parameter int IW = TFT_IW
)
(
  input wire logic mclk,
  input wire logic ce,
  input wire logic chip_rst,
  input wire logic we,
  input wire logic [IW-1:0] waddr,
  input wire logic [7:0] wbe,
  input wire logic [63:0] wdata,
  input wire logic [IW-1:0] a_addr,
  output logic [63:0] a_rdata,
  input wire logic [IW-1:0] b_addr,
  output logic [63:0] b_rdata
);
  logic [63:0] mem_q [DEPTH];

  // ==========================================================================
  // Storage: only the full chip reset clears it
  for (genvar i = 0; i < DEPTH; i++)
  begin : g_ent
    for (genvar b = 0; b < 8; b++)
    begin : g_byte
      always_ff @(posedge mclk)
      begin
        if (chip_rst)
          mem_q[i][8*b +: 8] <= TFT_ENTRY_RESET[8*b +: 8];
        else if (ce && we && waddr == IW'(i) && wbe[b])
          mem_q[i][8*b +: 8] <= wdata[8*b +: 8] & TFT_WMASK[8*b +: 8];
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (chip_rst)
    begin
      a_rdata <= TFT_ENTRY_RESET;
      b_rdata <= TFT_ENTRY_RESET;
    end
    else if (ce)
    begin
      a_rdata <= mem_q[a_addr];
      b_rdata <= mem_q[b_addr];
    end
  end
endmodule

// [test/tft_fence_table_checker.sv]
// Port checks of the tiled fence table
`timescale 1ns/1ps
module tft_fence_table_checker
  import tft_pkg::*;
#(
  parameter int DEPTH = TFT_DEPTH
)
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire tft_req_s acc_req,
  input wire logic acc_valid,
  input wire logic acc_ready,
  input wire tft_rsp_s acc_rsp,
  input wire logic acc_rsp_valid,
  input wire logic acc_rsp_ready
);
  // Bound writes during a scan restart it, so allow a few scans
  localparam int MAXLAT = 3 * DEPTH + 12;
  logic [31:0] req_q;
  default clocking @(posedge mclk);
  endclocking
  default disable iff (rst);
  always_ff @(posedge mclk)
    if (acc_valid && acc_ready)
      req_q <= acc_req.addr;
  sequence s_take;
    acc_valid && acc_ready;
  endsequence
  sequence s_wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  chk_take_busy: assert property (s_take |=> !acc_ready)
    else $error("lookup accepted while busy");
  chk_lookup_bound: assert property (s_take |-> ##[1:MAXLAT] acc_rsp_valid)
    else $error("lookup answer late");
  chk_rsp_hold: assert property (acc_rsp_valid && !acc_rsp_ready |=> acc_rsp_valid && $stable(acc_rsp))
    else $error("lookup answer dropped");
  chk_miss_pass: assert property (acc_rsp_valid && !acc_rsp.hit |-> acc_rsp.addr == req_q && acc_rsp.idx == 0)
    else $error("miss altered address");
  chk_ready_back: assert property (acc_rsp_valid && acc_rsp_ready |=> acc_ready)
    else $error("lookup not idle after answer");
  chk_b_latency: assert property (s_wr_both |-> ##2 s_axi_bvalid)
    else $error("write response late");
  chk_r_latency: assert property (s_axi_arvalid && s_axi_arready |-> ##2 s_axi_rvalid)
    else $error("read data late");
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
endmodule
bind tft_fence_table tft_fence_table_checker #(.DEPTH(DEPTH)) i_chk (.*);

// [test/tft_host_model.sv]
// Host model issuing aperture accesses to the fence lookup
`timescale 1ns/1ps
module tft_host_model
  import tft_pkg::*;
(
  input wire logic mclk,
  output tft_req_s acc_req,
  output logic acc_valid,
  input wire logic acc_ready,
  input wire tft_rsp_s acc_rsp,
  input wire logic acc_rsp_valid,
  output logic acc_rsp_ready
);
  initial
  begin
    acc_req = '0;
    acc_valid = 1'b0;
    acc_rsp_ready = 1'b0;
  end
  // Idle request lines show junk, not the last offset
  task automatic access(input logic [31:0] a, input int stall, output tft_rsp_s r);
    acc_req <= a;
    acc_valid <= 1'b1;
    do @(posedge mclk); while (!acc_ready);
    acc_valid <= 1'b0;
    acc_req <= ~a;
    repeat (stall) @(posedge mclk);
    acc_rsp_ready <= 1'b1;
    do @(posedge mclk); while (!acc_rsp_valid);
    r = acc_rsp;
    acc_rsp_ready <= 1'b0;
  endtask
endmodule

// [test/tft_fence_table_tb.sv]
// Self-checking bench of the tiled fence table
`timescale 1ns/1ps
module tft_fence_table_tb
  import tft_pkg::*;
;
  logic mclk = 1'b0, rst = 1'b1, chip_rst = 1'b1, ce = 1'b1, ctrl_en = 1'b1;
  logic [TFT_AW-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = '0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic acc_valid, acc_ready, acc_rsp_valid, acc_rsp_ready;
  tft_req_s acc_req;
  tft_rsp_s acc_rsp;
  tft_rsp_s last_rsp = '0;
  logic [63:0] ent [TFT_DEPTH];
  int fails = 0, n_tests = 0, cyc = 0;
  always #2.5 mclk = ~mclk;
  tft_fence_table i_dut (.*);
  tft_host_model i_host (.*);
  task automatic stop_test();
    $display("%0d checks, %0d wrong", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      fails++;
      stop_test();
    end
  end
  task automatic cmp_reg(logic [33:0] e, logic [33:0] g);
    n_tests++;
    if (g !== e)
    begin
      fails++;
      $display("wrong value bus answer: expected %h, seen %h", e, g);
    end
  endtask
  task automatic cmp_rsp(tft_rsp_s e, tft_rsp_s g);
    n_tests++;
    if (g !== e)
    begin
      fails++;
      $display("wrong value lookup: expected %h, seen %h", e, g);
    end
  endtask
  function automatic logic [1:0] mresp(logic [15:0] a);
    return (a >= TFT_TABLE_BASE && a < TFT_TABLE_END) || a == TFT_CTRL_OFF ? TFT_RESP_OKAY : TFT_RESP_SLVERR;
  endfunction
  function automatic logic [33:0] mdl_rd(logic [15:0] a);
    if (a == TFT_CTRL_OFF)
      return {TFT_RESP_OKAY, 31'h0, ctrl_en};
    if (a == TFT_STAT_OFF)
      return {TFT_RESP_OKAY, 24'h0, last_rsp.hit, last_rsp.idx, 3'h0};
    if (mresp(a) != TFT_RESP_OKAY)
      return {TFT_RESP_SLVERR, 32'h0};
    return {TFT_RESP_OKAY, a[2] ? ent[a[6:3]][63:32] : ent[a[6:3]][31:0]};
  endfunction
  // Lowest index wins; both bound pages belong to the region
  function automatic tft_rsp_s mdl_look(logic [31:0] a);
    tft_entry_s e;
    int unsigned off, p, row, col, t;
    if (!ctrl_en)
      return '{1'b0, 4'h0, a};
    for (int i = 0; i < TFT_DEPTH; i++)
    begin
      e = ent[i];
      if (e.valid && a[31:12] >= e.lower && a[31:12] <= e.upper)
      begin
        off = a - {e.lower, 12'h000};
        p = (e.pitch + 1) * 128;
        row = off / p;
        col = off % p;
        if (e.walk)
          t = ((row / 32) * (p / 128) + col / 128) * 4096 + (col % 128 / 16) * 512 + (row % 32) * 16 + col % 16;
        else
          t = ((row / 8) * (p / 512) + col / 512) * 4096 + (row % 8) * 512 + col % 512;
        return '{1'b1, 4'(i), {e.lower, 12'h000} + t};
      end
    end
    return '{1'b0, 4'h0, a};
  endfunction
  task automatic axw(logic [15:0] a, logic [31:0] d, logic [3:0] s);
    logic aw, w;
    logic [63:0] m;
    aw = 1'b1;
    w = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge mclk);
      aw = aw && !s_axi_awready;
      w = w && !s_axi_wready;
      s_axi_awvalid <= aw;
      s_axi_wvalid <= w;
    end while (aw || w);
    do @(posedge mclk); while (!s_axi_bvalid);
    cmp_reg({mresp(a), 32'h0}, {s_axi_bresp, 32'h0});
    s_axi_bready <= 1'b0;
    m = {32'h0, {8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}} << (a[2] ? 32 : 0);
    if (mresp(a) == TFT_RESP_OKAY && a != TFT_CTRL_OFF)
      ent[a[6:3]] = (ent[a[6:3]] & ~m) | ({d, d} & m & TFT_WMASK);
    if (a == TFT_CTRL_OFF && s[0])
      ctrl_en = d[0];
    @(posedge mclk);
  endtask
  task automatic axr(logic [15:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge mclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge mclk); while (!s_axi_rvalid);
    cmp_reg(mdl_rd(a), {s_axi_rresp, s_axi_rdata});
    s_axi_rready <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic look(logic [31:0] a);
    tft_rsp_s r;
    i_host.access(a, $urandom % 4, r);
    last_rsp = mdl_look(a);
    cmp_rsp(last_rsp, r);
  endtask
  initial
  begin
    logic [19:0] lo;
    void'($urandom(32'hCED2D375));
    foreach (ent[i]) ent[i] = TFT_ENTRY_RESET;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    chip_rst <= 1'b0;
    @(posedge mclk);
    axr(TFT_CTRL_OFF);
    for (int i = 0; i < 32; i++) axr(16'(TFT_TABLE_BASE + 4 * i));
    $display("reset values done");
    for (int i = 0; i < 32; i++) axw(16'(TFT_TABLE_BASE + 4 * i), $urandom, 4'hF);
    for (int i = 0; i < 32; i++) axw(16'(TFT_TABLE_BASE + 4 * i), $urandom, 4'($urandom));
    for (int i = 0; i < 32; i++) axr(16'(TFT_TABLE_BASE + 4 * i));
    axw(16'h3100, $urandom, 4'hF);
    axr(16'h3100);
    $display("register access done");
    // Bases on tile rows; Y regions hold no display surface
    for (int i = 0; i < TFT_DEPTH; i++)
    begin
      lo = 20'h100 + 20'(i * 8 + $urandom % 16);
      axw(16'(TFT_TABLE_BASE + 8 * i + 4), {lo + 20'($urandom % 16), 12'h0}, 4'hF);
      axw(16'(TFT_TABLE_BASE + 8 * i), {lo, 10'($urandom % 8 * 4 + 3), 1'($urandom), 1'($urandom % 4 != 0)}, 4'hF);
    end
    for (int i = 0; i < 200; i++) look({20'h100 + 20'($urandom % 160), 12'($urandom)});
    axr(TFT_STAT_OFF);
    for (int i = 0; i < TFT_DEPTH; i++) look({ent[i][31:12], 12'h000});
    for (int i = 0; i < TFT_DEPTH; i++) look({ent[i][63:44], 12'hFFF});
    for (int i = 0; i < TFT_DEPTH; i++) look({ent[i][63:44] + 20'h1, 12'h000});
    axw(TFT_CTRL_OFF, 32'h0, 4'hF);
    look(32'h0010_8000);
    axw(TFT_CTRL_OFF, 32'h1, 4'hF);
    // Freeze the lookup mid-scan; the answer must still be right
    fork
      look({20'h100 + 20'($urandom % 160), 12'($urandom)});
      begin
        repeat (3) @(posedge mclk);
        ce <= 1'b0;
        repeat (6) @(posedge mclk);
        ce <= 1'b1;
      end
    join
    $display("lookups done");
    axw(16'(TFT_TABLE_BASE + 4), 32'hFFFF_F000, 4'hF);
    axw(TFT_TABLE_BASE, 32'h0, 4'hF);
    fork
      look(32'h0FF0_1234);
      begin
        repeat (5) @(posedge mclk);
        axw(TFT_TABLE_BASE, 32'h0000_000D, 4'hF);
      end
    join
    axr(TFT_STAT_OFF);
    $display("bound rewrite done");
    rst <= 1'b1;
    @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    for (int i = 0; i < 4; i++) axr(16'(TFT_TABLE_BASE + 4 * i));
    chip_rst <= 1'b1;
    @(posedge mclk);
    chip_rst <= 1'b0;
    @(posedge mclk);
    foreach (ent[i]) ent[i] = TFT_ENTRY_RESET;
    for (int i = 0; i < 4; i++) axr(16'(TFT_TABLE_BASE + 4 * i));
    look(32'h0010_0000);
    $display("reset retention done");
    stop_test();
  end
endmodule
